// ==== core/aoc_offset_control_regs.sv ====
// Offset trim registers, even-pixel trim selection and control/polarity logic
`timescale 1ns/1ps
`default_nettype none
module aoc_offset_control_regs (
  input  wire logic                       CLK_IN,
  input  wire logic                       ARST_N_IN,
  input  wire aoc_pkg::aoc_reg_req_t      REG_REQ_IN,
  output logic [aoc_pkg::DATA_W-1:0]      REG_RD_DATA_OUT,
  input  wire logic                       ALT_PIXEL_MODE_IN,
  input  wire logic                       PIXEL_EVEN_IN,
  input  wire aoc_pkg::aoc_trim3_t        COARSE_TRIM_IN,
  input  wire aoc_pkg::aoc_timing_t       TIMING_PINS_IN,
  input  wire logic [aoc_pkg::CONV_W-1:0] CONV_DATA_IN,
  output aoc_pkg::aoc_trim3_t             COARSE_TRIM_OUT,
  output aoc_pkg::aoc_trim3_t             FINE_TRIM_OUT,
  output aoc_pkg::aoc_timing_t            TIMING_ACTIVE_OUT,
  output logic                            VIDEO_SAMPLE_STROBE_OUT,
  output logic                            BLACK_SAMPLE_STROBE_OUT,
  output logic                            LOW_POWER_DISABLE_OUT,
  output logic                            POWER_DOWN_OUT,
  output logic [aoc_pkg::CONV_W-1:0]      CONV_BUS_OUT,
  output logic                            CONV_BUS_OE_OUT
);
  import aoc_pkg::*;

  aoc_state_t  state;
  aoc_state_t  next_state;
  aoc_timing_t polarity;
  aoc_timing_t active;
  aoc_timing_t active_prev;
  logic        soft_reset;
  logic        use_even;

  // Registered read mux; the self-clearing reset bit always reads zero
  function automatic logic [DATA_W-1:0] read_reg(input aoc_state_t s,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] r;
    r = RD_UNMAPPED;
    case (a)
      ADDR_RED_FINE_TRIM:          r = s.fine[CH_RED];
      ADDR_GREEN_FINE_TRIM:        r = s.fine[CH_GREEN];
      ADDR_BLUE_FINE_TRIM:         r = s.fine[CH_BLUE];
      ADDR_EVEN_RED_COARSE_TRIM:   r = s.even_coarse[CH_RED];
      ADDR_EVEN_GREEN_COARSE_TRIM: r = s.even_coarse[CH_GREEN];
      ADDR_EVEN_BLUE_COARSE_TRIM:  r = s.even_coarse[CH_BLUE];
      ADDR_EVEN_RED_FINE_TRIM:     r = s.even_fine[CH_RED];
      ADDR_EVEN_GREEN_FINE_TRIM:   r = s.even_fine[CH_GREEN];
      ADDR_EVEN_BLUE_FINE_TRIM:    r = s.even_fine[CH_BLUE];
      ADDR_CONTROL_AND_POLARITY:   r = {2'h0, s.ctrl[7:1], 1'b0};
      default:                     r = RD_UNMAPPED;
    endcase
    return r;
  endfunction : read_reg

  always_comb begin
    next_state = state;
    soft_reset = REG_REQ_IN.wr && (REG_REQ_IN.addr == ADDR_CONTROL_AND_POLARITY)
                 && REG_REQ_IN.wdata[BIT_SOFT_RESET];

    // Register writes
    if (REG_REQ_IN.wr) begin
      case (REG_REQ_IN.addr)
        ADDR_RED_FINE_TRIM:          next_state.fine[CH_RED] = REG_REQ_IN.wdata;
        ADDR_GREEN_FINE_TRIM:        next_state.fine[CH_GREEN] = REG_REQ_IN.wdata;
        ADDR_BLUE_FINE_TRIM:         next_state.fine[CH_BLUE] = REG_REQ_IN.wdata;
        ADDR_EVEN_RED_COARSE_TRIM:   next_state.even_coarse[CH_RED] = REG_REQ_IN.wdata;
        ADDR_EVEN_GREEN_COARSE_TRIM: next_state.even_coarse[CH_GREEN] = REG_REQ_IN.wdata;
        ADDR_EVEN_BLUE_COARSE_TRIM:  next_state.even_coarse[CH_BLUE] = REG_REQ_IN.wdata;
        ADDR_EVEN_RED_FINE_TRIM:     next_state.even_fine[CH_RED] = REG_REQ_IN.wdata;
        ADDR_EVEN_GREEN_FINE_TRIM:   next_state.even_fine[CH_GREEN] = REG_REQ_IN.wdata;
        ADDR_EVEN_BLUE_FINE_TRIM:    next_state.even_fine[CH_BLUE] = REG_REQ_IN.wdata;
        ADDR_CONTROL_AND_POLARITY:   next_state.ctrl = {REG_REQ_IN.wdata[7:1], 1'b0};
        default:                     next_state.ctrl = state.ctrl;
      endcase
    end

    // Soft reset overrides the write itself, so the bit never stays set
    if (soft_reset) begin
      next_state.fine        = {NUM_CH{RST_FINE_TRIM}};
      next_state.even_coarse = {NUM_CH{RST_COARSE_TRIM}};
      next_state.even_fine   = {NUM_CH{RST_FINE_TRIM}};
      next_state.ctrl        = RST_CONTROL;
    end

    // Per-pixel trim selection; mode is not qualified with fixed gain mode
    // because the host keeps that pairing
    use_even = ALT_PIXEL_MODE_IN && PIXEL_EVEN_IN;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_state.sel_coarse[ch] = use_even ? state.even_coarse[ch] : COARSE_TRIM_IN[ch];
      next_state.sel_fine[ch]   = use_even ? state.even_fine[ch] : state.fine[ch];
    end

    // Timing pins: two-stage synchroniser, then polarity normalisation
    next_state.sync1 = TIMING_PINS_IN;
    next_state.sync2 = state.sync1;
    polarity = {state.ctrl[BIT_CONVERTER_CLOCK_POLARITY],
                state.ctrl[BIT_LINE_CLAMP_POLARITY],
                state.ctrl[BIT_BLACK_SAMPLE_POLARITY],
                state.ctrl[BIT_VIDEO_SAMPLE_POLARITY]};
    active      = state.sync2 ^ polarity;
    active_prev = state.prev ^ polarity;
    next_state.prev = state.sync2;
    // Sample at the end of the active phase: falling edge when active high,
    // rising edge when active low; both phases use the current polarity, so a polarity change alone never strobes
    next_state.video_strobe = active_prev[TIM_VIDEO_SAMPLE]
                              && !active[TIM_VIDEO_SAMPLE];
    next_state.black_strobe = active_prev[TIM_BLACK_SAMPLE]
                              && !active[TIM_BLACK_SAMPLE];

    // Conversion data frozen while powered down to save switching
    if (!state.ctrl[BIT_POWER_DOWN]) begin
      next_state.conv = CONV_DATA_IN;
    end
    next_state.conv_oe = !state.ctrl[BIT_OUTPUT_ENABLE_BAR];

    next_state.rd_data = read_reg(state, REG_REQ_IN.addr);
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state.fine         <= {NUM_CH{RST_FINE_TRIM}};
      state.even_coarse  <= {NUM_CH{RST_COARSE_TRIM}};
      state.even_fine    <= {NUM_CH{RST_FINE_TRIM}};
      state.ctrl         <= RST_CONTROL;
      state.sync1        <= 4'h0;
      state.sync2        <= 4'h0;
      state.prev         <= 4'h0;
      state.sel_coarse   <= {NUM_CH{RST_COARSE_TRIM}};
      state.sel_fine     <= {NUM_CH{RST_FINE_TRIM}};
      state.rd_data      <= RD_UNMAPPED;
      state.conv         <= RST_CONV;
      state.conv_oe      <= 1'b0;
      state.video_strobe <= 1'b0;
      state.black_strobe <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign REG_RD_DATA_OUT         = state.rd_data;
  assign COARSE_TRIM_OUT         = state.sel_coarse;
  assign FINE_TRIM_OUT           = state.sel_fine;
  assign TIMING_ACTIVE_OUT       = state.prev ^ {state.ctrl[BIT_CONVERTER_CLOCK_POLARITY],
                                                 state.ctrl[BIT_LINE_CLAMP_POLARITY],
                                                 state.ctrl[BIT_BLACK_SAMPLE_POLARITY],
                                                 state.ctrl[BIT_VIDEO_SAMPLE_POLARITY]};
  assign VIDEO_SAMPLE_STROBE_OUT = state.video_strobe;
  assign BLACK_SAMPLE_STROBE_OUT = state.black_strobe;
  assign LOW_POWER_DISABLE_OUT   = state.ctrl[BIT_LOW_POWER_DISABLE];
  assign POWER_DOWN_OUT          = state.ctrl[BIT_POWER_DOWN];
  assign CONV_BUS_OUT            = state.conv;
  assign CONV_BUS_OE_OUT         = state.conv_oe;

endmodule : aoc_offset_control_regs
`default_nettype wire

// ==== core/aoc_pkg.sv ====
// Package for the offset trim and control register bank
package aoc_pkg;

  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned DATA_W  = 10;
  localparam int unsigned CONV_W  = 16;
  localparam int unsigned NUM_CH  = 3;

  // Channel indices
  localparam int unsigned CH_RED   = 0;
  localparam int unsigned CH_GREEN = 1;
  localparam int unsigned CH_BLUE  = 2;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_RED_FINE_TRIM          = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_GREEN_FINE_TRIM        = 5'h07;
  localparam logic [ADDR_W-1:0] ADDR_BLUE_FINE_TRIM         = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_EVEN_RED_COARSE_TRIM   = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_EVEN_GREEN_COARSE_TRIM = 5'h0A;
  localparam logic [ADDR_W-1:0] ADDR_EVEN_BLUE_COARSE_TRIM  = 5'h0B;
  localparam logic [ADDR_W-1:0] ADDR_EVEN_RED_FINE_TRIM     = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_EVEN_GREEN_FINE_TRIM   = 5'h0D;
  localparam logic [ADDR_W-1:0] ADDR_EVEN_BLUE_FINE_TRIM    = 5'h0E;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_AND_POLARITY   = 5'h0F;

  // Reset values
  localparam logic [DATA_W-1:0] RST_FINE_TRIM   = 10'h200;
  localparam logic [DATA_W-1:0] RST_COARSE_TRIM = 10'h155;
  localparam logic [7:0]        RST_CONTROL     = 8'h00;
  localparam logic [CONV_W-1:0] RST_CONV        = 16'h0000;
  localparam logic [DATA_W-1:0] RD_UNMAPPED     = 10'h000;

  // Control and polarity bit positions
  localparam int unsigned BIT_CONVERTER_CLOCK_POLARITY = 7;
  localparam int unsigned BIT_LINE_CLAMP_POLARITY      = 6;
  localparam int unsigned BIT_BLACK_SAMPLE_POLARITY    = 5;
  localparam int unsigned BIT_VIDEO_SAMPLE_POLARITY    = 4;
  localparam int unsigned BIT_LOW_POWER_DISABLE        = 3;
  localparam int unsigned BIT_POWER_DOWN               = 2;
  localparam int unsigned BIT_OUTPUT_ENABLE_BAR        = 1;
  localparam int unsigned BIT_SOFT_RESET               = 0;

  // Timing input indices in the timing vectors
  localparam int unsigned TIM_CONVERTER_CLOCK = 3;
  localparam int unsigned TIM_LINE_CLAMP      = 2;
  localparam int unsigned TIM_BLACK_SAMPLE    = 1;
  localparam int unsigned TIM_VIDEO_SAMPLE    = 0;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] aoc_trim3_t;
  typedef logic [3:0]                    aoc_timing_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
  } aoc_reg_req_t;

  typedef struct packed {
    aoc_trim3_t        fine;
    aoc_trim3_t        even_coarse;
    aoc_trim3_t        even_fine;
    logic [7:0]        ctrl;
    aoc_timing_t       sync1;
    aoc_timing_t       sync2;
    aoc_timing_t       prev;
    aoc_trim3_t        sel_coarse;
    aoc_trim3_t        sel_fine;
    logic [DATA_W-1:0] rd_data;
    logic [CONV_W-1:0] conv;
    logic              conv_oe;
    logic              video_strobe;
    logic              black_strobe;
  } aoc_state_t;

endpackage : aoc_pkg

// ==== tb/aoc_host_model.sv ====
// Host controller model issuing register writes, reads and the offset mode bit
`timescale 1ns/1ps
`default_nettype none
module aoc_host_model (
  input  wire logic                 CLK_IN,
  output var aoc_pkg::aoc_reg_req_t REQ_OUT,
  output var logic                  ALT_MODE_OUT
);
  import aoc_pkg::*;
  initial begin
    REQ_OUT = '0;
    ALT_MODE_OUT = 1'b0;
  end
  task automatic put(input logic [4:0] a, input logic [9:0] d);
    @(negedge CLK_IN);
    REQ_OUT = '{addr: a, wdata: d, wr: 1'b1};
    @(negedge CLK_IN);
    REQ_OUT.wr = 1'b0;
  endtask : put
  task automatic look(input logic [4:0] a);
    @(negedge CLK_IN);
    REQ_OUT.addr = a;
    // Idle write data keeps moving so a stale value is never mistaken for a write
    REQ_OUT.wdata = ~REQ_OUT.wdata;
    @(negedge CLK_IN);
  endtask : look
  // Only called with fixed gain/offset mode assumed selected
  task automatic mode(input logic m);
    @(negedge CLK_IN);
    ALT_MODE_OUT = m;
  endtask : mode
endmodule : aoc_host_model
`default_nettype wire

// ==== tb/aoc_props.sv ====
// Concurrent checks on the offset trim and control register bank ports
`timescale 1ns/1ps
`default_nettype none
module aoc_props (
  input wire logic                 CLK_IN,
  input wire logic                 ARST_N_IN,
  input wire aoc_pkg::aoc_reg_req_t REG_REQ_IN,
  input wire logic [9:0]           REG_RD_DATA_OUT,
  input wire logic                 ALT_PIXEL_MODE_IN,
  input wire logic                 PIXEL_EVEN_IN,
  input wire aoc_pkg::aoc_trim3_t  COARSE_TRIM_IN,
  input wire aoc_pkg::aoc_trim3_t  COARSE_TRIM_OUT,
  input wire aoc_pkg::aoc_timing_t TIMING_ACTIVE_OUT,
  input wire logic                 VIDEO_SAMPLE_STROBE_OUT,
  input wire logic                 LOW_POWER_DISABLE_OUT,
  input wire logic                 POWER_DOWN_OUT,
  input wire logic [15:0]          CONV_DATA_IN,
  input wire logic [15:0]          CONV_BUS_OUT,
  input wire logic                 CONV_BUS_OE_OUT
);
  import aoc_pkg::*;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence ctrl_wr_s;
    REG_REQ_IN.wr && REG_REQ_IN.addr == ADDR_CONTROL_AND_POLARITY;
  endsequence
  ctrl_read_a: assert property (
    $past(REG_REQ_IN.addr) == ADDR_CONTROL_AND_POLARITY |-> REG_RD_DATA_OUT[9:8] == 2'h0
    && !REG_RD_DATA_OUT[0]) else $error("control spare bits read set");
  unmapped_read_a: assert property (
    !($past(REG_REQ_IN.addr) inside {[ADDR_RED_FINE_TRIM:ADDR_CONTROL_AND_POLARITY]})
    |-> REG_RD_DATA_OUT == RD_UNMAPPED) else $error("unmapped read not zero");
  oe_follow_a: assert property (
    ctrl_wr_s ##0 !REG_REQ_IN.wdata[0] |=> ##1 CONV_BUS_OE_OUT == !$past(REG_REQ_IN.wdata[1], 2))
    else $error("output enable wrong");
  soft_reset_a: assert property (
    ctrl_wr_s ##0 REG_REQ_IN.wdata[0] |=> !POWER_DOWN_OUT && !LOW_POWER_DISABLE_OUT
    ##1 CONV_BUS_OE_OUT) else $error("soft reset incomplete");
  pdown_bit_a: assert property (
    ctrl_wr_s ##0 !REG_REQ_IN.wdata[0] |=> POWER_DOWN_OUT == $past(REG_REQ_IN.wdata[2]))
    else $error("power down bit wrong");
  conv_live_a: assert property (
    !POWER_DOWN_OUT |=> CONV_BUS_OUT == $past(CONV_DATA_IN)) else $error("bus not live");
  conv_hold_a: assert property (
    POWER_DOWN_OUT |=> $stable(CONV_BUS_OUT)) else $error("bus moved in power down");
  odd_trim_a: assert property (
    !(ALT_PIXEL_MODE_IN && PIXEL_EVEN_IN) |=> COARSE_TRIM_OUT == $past(COARSE_TRIM_IN))
    else $error("odd pixel coarse trim wrong");
  video_strobe_a: assert property (
    $fell(TIMING_ACTIVE_OUT[TIM_VIDEO_SAMPLE]) |-> VIDEO_SAMPLE_STROBE_OUT
    ##1 !VIDEO_SAMPLE_STROBE_OUT) else $error("video strobe wrong");
endmodule : aoc_props
bind aoc_offset_control_regs aoc_props u_props (.*);
`default_nettype wire

// ==== tb/test_afe_offset_control_regs.sv ====
// Self-checking bench for the offset trim and control register bank
`timescale 1ns/1ps
`default_nettype none
module test_afe_offset_control_regs;
  import aoc_pkg::*;
  logic         clk = 1'b0, arst_n = 1'b0, even = 1'b0;
  aoc_trim3_t   coarse = {10'h333, 10'h222, 10'h111};
  aoc_timing_t  pins = 4'h0;
  logic [15:0]  conv = 16'hA5A5;
  aoc_reg_req_t req;
  logic         alt, vs, bs, lpd, pd, oe;
  logic [9:0]   rd;
  aoc_trim3_t   c_out, f_out;
  aoc_timing_t  act;
  logic [15:0]  bus;
  int           num_errors, check_count, cycles, vcnt, bcnt;
  // Row: address, reset value, write value, expected read back
  logic [34:0]  rows [11] = '{{5'h06, 10'h200, 10'h2AB, 10'h2AB}, {5'h07, 10'h200, 10'h0CD, 10'h0CD},
    {5'h08, 10'h200, 10'h3F0, 10'h3F0}, {5'h09, 10'h155, 10'h3FF, 10'h3FF},
    {5'h0A, 10'h155, 10'h000, 10'h000}, {5'h0B, 10'h155, 10'h1A5, 10'h1A5},
    {5'h0C, 10'h200, 10'h3FF, 10'h3FF}, {5'h0D, 10'h200, 10'h000, 10'h000},
    {5'h0E, 10'h200, 10'h0F5, 10'h0F5}, {5'h0F, 10'h000, 10'h3FE, 10'h0FE},
    {5'h12, 10'h000, 10'h155, 10'h000}};
  always #5 clk = ~clk;
  aoc_host_model host (.CLK_IN(clk), .REQ_OUT(req), .ALT_MODE_OUT(alt));
  aoc_offset_control_regs dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .REG_REQ_IN(req),
    .REG_RD_DATA_OUT(rd), .ALT_PIXEL_MODE_IN(alt), .PIXEL_EVEN_IN(even),
    .COARSE_TRIM_IN(coarse), .TIMING_PINS_IN(pins), .CONV_DATA_IN(conv),
    .COARSE_TRIM_OUT(c_out), .FINE_TRIM_OUT(f_out), .TIMING_ACTIVE_OUT(act),
    .VIDEO_SAMPLE_STROBE_OUT(vs), .BLACK_SAMPLE_STROBE_OUT(bs), .LOW_POWER_DISABLE_OUT(lpd),
    .POWER_DOWN_OUT(pd), .CONV_BUS_OUT(bus), .CONV_BUS_OE_OUT(oe));
  function automatic logic [9:0] w(input int i);
    return rows[i][19:10];
  endfunction : w
  task automatic chk(input logic [29:0] got, input logic [29:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic sweep();
    for (int i = 0; i < 11; i++) begin
      host.look(rows[i][34:30]);
      chk(rd, rows[i][29:20], "reset value");
    end
  endtask : sweep
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // Whole run is about 120 cycles, so this only fires on a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    sweep();
    foreach (rows[i]) begin
      host.put(rows[i][34:30], w(i));
      host.look(rows[i][34:30]);
      chk(rd, rows[i][9:0], "readback");
    end
    for (int k = 0; k < 4; k++) begin
      host.mode(k[1]);
      even = k[0];
      repeat (2) @(negedge clk);
      chk(c_out, (k == 3) ? {w(5), w(4), w(3)} : coarse, "coarse select");
      chk(f_out, (k == 3) ? {w(8), w(7), w(6)} : {w(2), w(1), w(0)}, "fine select");
    end
    chk(act, 4'hF, "inverted inputs idle");
    pins = 4'hF;
    repeat (8) begin
      @(negedge clk);
      vcnt += (vs === 1'b1);
      bcnt += (bs === 1'b1);
    end
    chk(act, 4'h0, "inverted inputs high");
    chk({vcnt[3:0], bcnt[3:0]}, 8'h11, "sample strobes");
    conv = 16'h5A5A;
    repeat (2) @(negedge clk);
    chk({oe, pd, lpd, bus}, {3'h3, 16'hA5A5}, "power down hold");
    host.put(ADDR_CONTROL_AND_POLARITY, 10'h3FF);
    repeat (3) @(negedge clk);
    chk({oe, pd, lpd, bus, act}, {3'h4, 16'h5A5A, 4'hF}, "soft reset");
    sweep();
    final_report();
  end
endmodule : test_afe_offset_control_regs
`default_nettype wire
